// file: hdl/bkm_params.svh
// constants for the burst key stream xor mapper: offsets, data bit counts, register map
// assumes inclusion by bare name from the package and the design modules
`ifndef BKM_PARAMS_SVH
`define BKM_PARAMS_SVH

// key stream bit index offsets ahead of the b-field
`define BKM_OFS_STD 13'h028
`define BKM_OFS_4A 13'h050
`define BKM_OFS_4B 13'h078
// a-field bit that takes key stream bit 0
`define BKM_A_FIRST_BIT 13'h008
// multisubfield layout: key bits per subfield and data bits used of them
`define BKM_SUB_KEY_LEN 7'h50
`define BKM_SUB_DATA_LEN 7'h40

// unprotected data bits, groups 1a/1b, 2/4a, 3/4b, 5, 6
`define BKM_UNP_DBL_0 13'h320
`define BKM_UNP_DBL_1 13'h640
`define BKM_UNP_DBL_2 13'h960
`define BKM_UNP_DBL_3 13'hc80
`define BKM_UNP_DBL_4 13'h12c0
`define BKM_UNP_FUL_0 13'h140
`define BKM_UNP_FUL_1 13'h280
`define BKM_UNP_FUL_2 13'h3c0
`define BKM_UNP_FUL_3 13'h500
`define BKM_UNP_FUL_4 13'h780
`define BKM_UNP_HLF_0 13'h050
`define BKM_UNP_HLF_1 13'h0a0
`define BKM_UNP_HLF_2 13'h0f0
`define BKM_UNP_HLF_3 13'h140
`define BKM_UNP_HLF_4 13'h230
`define BKM_UNP_L640_0 13'h280
`define BKM_UNP_L640_1 13'h500
`define BKM_UNP_L640_2 13'h780
`define BKM_UNP_L640_3 13'ha00
`define BKM_UNP_L640_4 13'hf00
`define BKM_UNP_L672_0 13'h2a0
`define BKM_UNP_L672_1 13'h540
`define BKM_UNP_L672_2 13'h7e0
`define BKM_UNP_L672_3 13'ha80
`define BKM_UNP_L672_4 13'hfc0

// single subfield protected data bits, same groups
`define BKM_SGL_DBL_0 13'h300
`define BKM_SGL_DBL_1 13'h620
`define BKM_SGL_DBL_2 13'h940
`define BKM_SGL_DBL_3 13'hc60
`define BKM_SGL_DBL_4 13'h12a0
`define BKM_SGL_FUL_0 13'h130
`define BKM_SGL_FUL_1 13'h260
`define BKM_SGL_FUL_2 13'h3a0
`define BKM_SGL_FUL_3 13'h4e0
`define BKM_SGL_FUL_4 13'h760
`define BKM_SGL_L640_0 13'h260
`define BKM_SGL_L640_1 13'h4e0
`define BKM_SGL_L640_2 13'h760
`define BKM_SGL_L640_3 13'h9e0
`define BKM_SGL_L640_4 13'hee0
`define BKM_SGL_L672_0 13'h280
`define BKM_SGL_L672_1 13'h520
`define BKM_SGL_L672_2 13'h7c0
`define BKM_SGL_L672_3 13'h9fc
`define BKM_SGL_L672_4 13'hfa0
// no single subfield count exists for the half slot
`define BKM_SGL_HLF 13'h000

// multisubfield: subfields = group multiplier times slot base
`define BKM_MSF_MUL_0 13'h001
`define BKM_MSF_MUL_1 13'h002
`define BKM_MSF_MUL_2 13'h003
`define BKM_MSF_MUL_3 13'h004
`define BKM_MSF_MUL_4 13'h006
`define BKM_MSF_BASE_DBL 13'h00a
`define BKM_MSF_BASE_FUL 13'h004
`define BKM_MSF_BASE_HLF 13'h001
`define BKM_MSF_BASE_LNG 13'h008

// register map (byte addresses) and reset values
`define BKM_REG_CTRL 8'h00
`define BKM_REG_STATUS 8'h04
`define BKM_REG_BURSTS 8'h08
`define BKM_CTRL_RESET 1'h1

`endif

// file: hdl/bkm_pkg.sv
// types for the burst key stream xor mapper
// assumes bkm_params.svh is on the include path
`include "bkm_params.svh"

package bkm_pkg;
	typedef enum logic [2:0] {bkm_cfg_1a, bkm_cfg_1b, bkm_cfg_2, bkm_cfg_3,
		bkm_cfg_4a, bkm_cfg_4b, bkm_cfg_5, bkm_cfg_6} bkm_cfg_e;
	typedef enum logic [2:0] {bkm_slot_double, bkm_slot_full, bkm_slot_half,
		bkm_slot_long640, bkm_slot_long672} bkm_slot_e;
	typedef enum logic [1:0] {bkm_fmt_unprot, bkm_fmt_single, bkm_fmt_multi} bkm_fmt_e;
	typedef enum logic [1:0] {bkm_ph_idle, bkm_ph_afield, bkm_ph_bfield, bkm_ph_done} bkm_phase_e;

	typedef struct packed {
		bkm_phase_e phase;
		bkm_cfg_e cfg;
		bkm_fmt_e fmt;
		logic tail_ctl;
		logic [12:0] offset;
		logic [12:0] count;
		logic [12:0] key_idx;
		logic [12:0] b_idx;
		logic [6:0] sub_i;
		logic out_valid;
		logic out_bit;
		logic out_is_b;
		logic [12:0] out_idx;
		logic [12:0] out_ks_idx;
		logic enc_en;
		logic [15:0] bursts;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] rdata;
	} bkm_state_s;
endpackage : bkm_pkg

// file: hdl/bkm_count_lut.sv
// lookup of encrypted b-field data bits for one slot type, configuration and format
// assumes purely combinational use by the mapper on the same clock
`include "bkm_params.svh"

module bkm_count_lut (
	input bkm_pkg::bkm_cfg_e i_cfg,
	input bkm_pkg::bkm_slot_e i_slot,
	input bkm_pkg::bkm_fmt_e i_fmt,
	output logic [12:0] o_count
);
	logic [2:0] grp;
	logic [12:0] base;
	logic [25:0] prod;

	// pick one of five grouped values
	function automatic logic [12:0] bkm_pick(input logic [2:0] g, input logic [12:0] v0, input logic [12:0] v1,
		input logic [12:0] v2, input logic [12:0] v3, input logic [12:0] v4);
		logic [12:0] r;
		unique case (g)
			3'h0: r = v0;
			3'h1: r = v1;
			3'h2: r = v2;
			3'h3: r = v3;
			default: r = v4;
		endcase
		return r;
	endfunction : bkm_pick

	// configurations sharing a b-field modulation share a count
	always_comb begin
		unique case (i_cfg)
			bkm_pkg::bkm_cfg_1a, bkm_pkg::bkm_cfg_1b: grp = 3'h0;
			bkm_pkg::bkm_cfg_2, bkm_pkg::bkm_cfg_4a: grp = 3'h1;
			bkm_pkg::bkm_cfg_3, bkm_pkg::bkm_cfg_4b: grp = 3'h2;
			bkm_pkg::bkm_cfg_5: grp = 3'h3;
			default: grp = 3'h4;
		endcase
	end

	// count by format and slot; multisubfield is subfields times data bits per subfield
	always_comb begin
		base = 13'h000;
		prod = 26'h0000000;
		o_count = 13'h000;
		unique case (i_fmt)
			bkm_pkg::bkm_fmt_unprot: begin
				unique case (i_slot)
					bkm_pkg::bkm_slot_double: o_count = bkm_pick(grp, `BKM_UNP_DBL_0, `BKM_UNP_DBL_1,
						`BKM_UNP_DBL_2, `BKM_UNP_DBL_3, `BKM_UNP_DBL_4);
					bkm_pkg::bkm_slot_full: o_count = bkm_pick(grp, `BKM_UNP_FUL_0, `BKM_UNP_FUL_1,
						`BKM_UNP_FUL_2, `BKM_UNP_FUL_3, `BKM_UNP_FUL_4);
					bkm_pkg::bkm_slot_half: o_count = bkm_pick(grp, `BKM_UNP_HLF_0, `BKM_UNP_HLF_1,
						`BKM_UNP_HLF_2, `BKM_UNP_HLF_3, `BKM_UNP_HLF_4);
					bkm_pkg::bkm_slot_long640: o_count = bkm_pick(grp, `BKM_UNP_L640_0, `BKM_UNP_L640_1,
						`BKM_UNP_L640_2, `BKM_UNP_L640_3, `BKM_UNP_L640_4);
					default: o_count = bkm_pick(grp, `BKM_UNP_L672_0, `BKM_UNP_L672_1,
						`BKM_UNP_L672_2, `BKM_UNP_L672_3, `BKM_UNP_L672_4);
				endcase
			end
			bkm_pkg::bkm_fmt_single: begin
				unique case (i_slot)
					bkm_pkg::bkm_slot_double: o_count = bkm_pick(grp, `BKM_SGL_DBL_0, `BKM_SGL_DBL_1,
						`BKM_SGL_DBL_2, `BKM_SGL_DBL_3, `BKM_SGL_DBL_4);
					bkm_pkg::bkm_slot_full: o_count = bkm_pick(grp, `BKM_SGL_FUL_0, `BKM_SGL_FUL_1,
						`BKM_SGL_FUL_2, `BKM_SGL_FUL_3, `BKM_SGL_FUL_4);
					bkm_pkg::bkm_slot_half: o_count = `BKM_SGL_HLF;
					bkm_pkg::bkm_slot_long640: o_count = bkm_pick(grp, `BKM_SGL_L640_0, `BKM_SGL_L640_1,
						`BKM_SGL_L640_2, `BKM_SGL_L640_3, `BKM_SGL_L640_4);
					default: o_count = bkm_pick(grp, `BKM_SGL_L672_0, `BKM_SGL_L672_1,
						`BKM_SGL_L672_2, `BKM_SGL_L672_3, `BKM_SGL_L672_4);
				endcase
			end
			default: begin
				unique case (i_slot)
					bkm_pkg::bkm_slot_double: base = `BKM_MSF_BASE_DBL;
					bkm_pkg::bkm_slot_full: base = `BKM_MSF_BASE_FUL;
					bkm_pkg::bkm_slot_half: base = `BKM_MSF_BASE_HLF;
					default: base = `BKM_MSF_BASE_LNG;
				endcase
				prod = bkm_pick(grp, `BKM_MSF_MUL_0, `BKM_MSF_MUL_1, `BKM_MSF_MUL_2,
					`BKM_MSF_MUL_3, `BKM_MSF_MUL_4) * base;
				o_count = 13'(prod[12:0] * 13'(`BKM_SUB_DATA_LEN));
			end
		endcase
	end
endmodule : bkm_count_lut

// file: hdl/bkm_mapper.sv
// burst key stream xor mapper: lays key stream segment bits onto a-field and b-field bits
// assumes key and data bits arrive together from logic on i_mclk; registers over ahb-lite
`include "bkm_params.svh"

module bkm_mapper (
	input wire i_mclk,
	input wire i_resetn,
	input wire i_start,
	input bkm_pkg::bkm_cfg_e i_cfg,
	input bkm_pkg::bkm_slot_e i_slot,
	input bkm_pkg::bkm_fmt_e i_fmt,
	input wire i_tail_ctl,
	input wire i_ks_valid,
	input wire i_ks_bit,
	input wire i_data_bit,
	output logic o_out_valid,
	output logic o_out_bit,
	output logic o_out_is_b,
	output logic [12:0] o_out_idx,
	output logic [12:0] o_out_ks_idx,
	output logic o_busy,
	output logic o_done,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp
);
	bkm_pkg::bkm_state_s st_r;
	bkm_pkg::bkm_state_s st_nxt;
	logic [12:0] lut_count;
	logic [12:0] start_offset;
	logic emit;
	logic addr_ok;
	logic [12:0] key_inc;

	// per-burst data bit count from slot, configuration and format
	bkm_count_lut u_count (
		.i_cfg(i_cfg),
		.i_slot(i_slot),
		.i_fmt(i_fmt),
		.o_count(lut_count)
	);

	// key index offset ahead of the b-field follows the a-field modulation
	always_comb begin
		unique case (i_cfg)
			bkm_pkg::bkm_cfg_4a: start_offset = `BKM_OFS_4A;
			bkm_pkg::bkm_cfg_4b: start_offset = `BKM_OFS_4B;
			default: start_offset = `BKM_OFS_STD;
		endcase
	end

	assign addr_ok = i_hsel && i_hready && i_htrans[1];
	assign key_inc = st_r.key_idx + 13'h001;

	// burst walk: one key bit per valid cycle, a-field first, then b-field
	always_comb begin
		st_nxt = st_r;
		emit = 1'b0;
		st_nxt.out_valid = 1'b0;
		if (i_start) begin
			// configuration held for the whole burst
			st_nxt.phase = bkm_pkg::bkm_ph_afield;
			st_nxt.cfg = i_cfg;
			st_nxt.fmt = i_fmt;
			st_nxt.tail_ctl = i_tail_ctl;
			st_nxt.offset = start_offset;
			st_nxt.count = lut_count;
			st_nxt.key_idx = 13'h000;
			st_nxt.b_idx = 13'h000;
			st_nxt.sub_i = 7'h00;
		end else if (i_ks_valid) begin
			unique case (st_r.phase)
				bkm_pkg::bkm_ph_afield: begin
					// leading key bits cover the a-field or are dropped
					if (st_r.tail_ctl) begin
						emit = 1'b1;
						st_nxt.out_is_b = 1'b0;
						st_nxt.out_idx = st_r.key_idx + `BKM_A_FIRST_BIT;
					end
					if (key_inc == st_r.offset) begin
						st_nxt.phase = (st_r.count == 13'h000) ? bkm_pkg::bkm_ph_done : bkm_pkg::bkm_ph_bfield;
					end
					st_nxt.key_idx = key_inc;
				end
				bkm_pkg::bkm_ph_bfield: begin
					// multisubfield skips the last 16 key bits of each 80 (check bits)
					if (st_r.fmt != bkm_pkg::bkm_fmt_multi || st_r.sub_i < `BKM_SUB_DATA_LEN) begin
						emit = 1'b1;
						st_nxt.out_is_b = 1'b1;
						st_nxt.out_idx = st_r.b_idx;
						st_nxt.b_idx = st_r.b_idx + 13'h001;
						if (st_r.b_idx == st_r.count - 13'h001) begin
							st_nxt.phase = bkm_pkg::bkm_ph_done;
						end
					end
					st_nxt.sub_i = (st_r.sub_i == `BKM_SUB_KEY_LEN - 7'h01) ? 7'h00 : st_r.sub_i + 7'h01;
					st_nxt.key_idx = key_inc;
				end
				bkm_pkg::bkm_ph_idle, bkm_pkg::bkm_ph_done: begin
					// surplus key bits are consumed without effect
					st_nxt.key_idx = st_r.key_idx;
				end
			endcase
		end
		if (emit) begin
			st_nxt.out_valid = 1'b1;
			st_nxt.out_bit = i_data_bit ^ (st_r.enc_en & i_ks_bit);
			st_nxt.out_ks_idx = st_r.key_idx;
		end
		if (!i_start && i_ks_valid && st_r.phase == bkm_pkg::bkm_ph_bfield && st_nxt.phase == bkm_pkg::bkm_ph_done) begin
			st_nxt.bursts = st_r.bursts + 16'h0001;
		end
		// ahb-lite data phase write of the control word
		if (st_r.dp_write && st_r.dp_addr == `BKM_REG_CTRL) begin
			st_nxt.enc_en = i_hwdata[0];
		end
		// ahb-lite address phase: capture write target, prepare read data
		st_nxt.dp_write = addr_ok && i_hwrite;
		st_nxt.dp_addr = addr_ok ? i_haddr[7:0] : st_r.dp_addr;
		if (addr_ok && !i_hwrite) begin
			unique case (i_haddr[7:0])
				`BKM_REG_CTRL: st_nxt.rdata = {31'h00000000, st_nxt.enc_en};
				`BKM_REG_STATUS: st_nxt.rdata = {3'h0, st_r.b_idx, 13'h0000, st_r.phase == bkm_pkg::bkm_ph_done,
					st_r.phase};
				`BKM_REG_BURSTS: st_nxt.rdata = {16'h0000, st_r.bursts};
				default: st_nxt.rdata = 32'h00000000;
			endcase
		end
	end

	// single register stage for all state
	always_ff @(posedge i_mclk) begin
		if (!i_resetn) begin
			st_r <= '0;
			st_r.phase <= bkm_pkg::bkm_ph_idle;
			st_r.enc_en <= `BKM_CTRL_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from flops, busy and done decoded from the phase flops; bus always ready with an okay answer
	assign o_out_valid = st_r.out_valid;
	assign o_out_bit = st_r.out_bit;
	assign o_out_is_b = st_r.out_is_b;
	assign o_out_idx = st_r.out_idx;
	assign o_out_ks_idx = st_r.out_ks_idx;
	assign o_busy = st_r.phase == bkm_pkg::bkm_ph_afield || st_r.phase == bkm_pkg::bkm_ph_bfield;
	assign o_done = st_r.phase == bkm_pkg::bkm_ph_done;
	assign o_hrdata = st_r.rdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;

	// helper: subfield position of the current b output
	logic [12:0] h_sub_x;
	logic [12:0] h_sub_i;
	assign h_sub_x = st_r.out_idx >> 6;
	assign h_sub_i = st_r.out_idx & 13'h003f;
	logic rd_req;
	assign rd_req = addr_ok && !i_hwrite;

	default clocking bkm_cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_resetn);

	b_index_map_a: assert property (o_out_valid && o_out_is_b && st_r.fmt != bkm_pkg::bkm_fmt_multi
		|-> o_out_ks_idx == o_out_idx + st_r.offset)
		else $error("b bit mapped to wrong key bit");
	offset_value_a: assert property (i_start && i_cfg == bkm_pkg::bkm_cfg_4b
		|=> st_r.offset == 13'd120)
		else $error("offset for 4b is not 120");
	multi_map_a: assert property (o_out_valid && o_out_is_b && st_r.fmt == bkm_pkg::bkm_fmt_multi
		|-> o_out_ks_idx == 13'(h_sub_x * 13'd80) + h_sub_i + st_r.offset)
		else $error("subfield bit mapped to wrong key bit");
	check_skip_a: assert property (o_out_valid && o_out_is_b && st_r.fmt == bkm_pkg::bkm_fmt_multi
		|-> ((o_out_ks_idx - st_r.offset) % 13'd80) < 13'd64)
		else $error("check bit position was encrypted");
	count_limit_a: assert property (o_out_valid && o_out_is_b |-> o_out_idx < st_r.count)
		else $error("b bit beyond data bit count");
	done_last_a: assert property ($rose(o_done) && st_r.count != 13'h000
		|-> o_out_valid && o_out_is_b && o_out_idx == st_r.count - 13'h001)
		else $error("burst ended on wrong bit");
	afield_map_a: assert property (o_out_valid && !o_out_is_b
		|-> st_r.tail_ctl && o_out_ks_idx < st_r.offset && o_out_idx == o_out_ks_idx + 13'd8)
		else $error("a-field bit misplaced");
	xor_value_a: assert property (i_ks_valid && !i_start && st_r.phase == bkm_pkg::bkm_ph_bfield
		&& st_r.fmt != bkm_pkg::bkm_fmt_multi ##1 o_out_valid
		|-> o_out_bit == ($past(i_data_bit) ^ ($past(st_r.enc_en) & $past(i_ks_bit))))
		else $error("output bit is not the xor");
	done_quiet_a: assert property (o_done && !i_start |=> !o_out_valid)
		else $error("output after burst end");

	// burst start latches the per-burst choices
	start_latch_a: assert property (i_start |=> st_r.cfg == $past(i_cfg) && st_r.fmt == $past(i_fmt)
		&& st_r.count == $past(lut_count) && st_r.offset == $past(start_offset))
		else $error("burst choices not latched");

	// start clears the walk and opens the a-field
	start_clear_a: assert property (i_start |=> o_busy && !o_out_valid && st_r.key_idx == 13'h000)
		else $error("start did not restart the walk");

	// choices stay put between starts
	cfg_hold_a: assert property (!i_start |=> $stable(st_r.cfg) && $stable(st_r.fmt)
		&& $stable(st_r.offset) && $stable(st_r.count) && $stable(st_r.tail_ctl))
		else $error("burst choices changed mid burst");

	// without a control-type tail the leading key bits leave no output
	tail_quiet_a: assert property (st_r.phase == bkm_pkg::bkm_ph_afield && !st_r.tail_ctl
		|=> !o_out_valid)
		else $error("a-field bit without control tail");

	// an idle walk ignores key bits
	idle_quiet_a: assert property (st_r.phase == bkm_pkg::bkm_ph_idle |=> !o_out_valid)
		else $error("output before any start");

	// every output comes from a consumed key bit
	out_source_a: assert property (o_out_valid |-> $past(i_ks_valid) && !$past(i_start))
		else $error("output without a key bit");

	// the last leading key bit hands over to the b-field, or to done for a zero count
	afield_exit_a: assert property (st_r.phase == bkm_pkg::bkm_ph_afield && i_ks_valid && !i_start
		&& key_inc == st_r.offset |=> st_r.phase != bkm_pkg::bkm_ph_afield && st_r.key_idx == st_r.offset)
		else $error("a-field did not end at the offset");

	// one key index per consumed bit while busy
	key_step_a: assert property (o_busy && i_ks_valid && !i_start
		|=> st_r.key_idx == $past(st_r.key_idx) + 13'h001)
		else $error("key index skipped");

	// no key bit, no movement
	key_hold_a: assert property (!i_ks_valid && !i_start
		|=> $stable(st_r.key_idx) && $stable(st_r.b_idx))
		else $error("walk moved without a key bit");

	// check bit positions of a subfield give no output
	check_quiet_a: assert property (st_r.phase == bkm_pkg::bkm_ph_bfield && i_ks_valid && !i_start
		&& st_r.fmt == bkm_pkg::bkm_fmt_multi && st_r.sub_i >= `BKM_SUB_DATA_LEN |=> !o_out_valid)
		else $error("check bit position produced output");

	// done stands until the next start
	done_hold_a: assert property (o_done && !i_start |=> o_done)
		else $error("done dropped without a start");

	// a burst through the b-field counts once
	burst_count_a: assert property ($rose(o_done) && st_r.count != 13'h000
		|-> st_r.bursts == $past(st_r.bursts) + 16'h0001)
		else $error("burst counter missed a burst");

	// control word write lands in its data phase and nowhere else
	ctrl_write_a: assert property (st_r.dp_write && st_r.dp_addr == `BKM_REG_CTRL
		|=> st_r.enc_en == $past(i_hwdata[0]))
		else $error("control write lost");
	ctrl_hold_a: assert property (!(st_r.dp_write && st_r.dp_addr == `BKM_REG_CTRL)
		|=> $stable(st_r.enc_en))
		else $error("control bit changed without a write");

	// read data of the mapped words stands in the data phase
	ctrl_read_a: assert property (rd_req && i_haddr[7:0] == `BKM_REG_CTRL
		|=> o_hrdata == {31'h00000000, st_r.enc_en})
		else $error("control read wrong");
	bursts_read_a: assert property (rd_req && i_haddr[7:0] == `BKM_REG_BURSTS
		|=> o_hrdata == {16'h0000, $past(st_r.bursts)})
		else $error("burst count read wrong");
	status_read_a: assert property (rd_req && i_haddr[7:0] == `BKM_REG_STATUS
		|=> o_hrdata[1:0] == $past(st_r.phase) && o_hrdata[28:16] == $past(st_r.b_idx))
		else $error("status read wrong");
	unmapped_zero_a: assert property (rd_req && i_haddr[7:0] != `BKM_REG_CTRL && i_haddr[7:0] != `BKM_REG_STATUS
		&& i_haddr[7:0] != `BKM_REG_BURSTS |=> o_hrdata == 32'h00000000)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!rd_req |=> $stable(o_hrdata))
		else $error("read data changed without a read");

	// first b bit takes the key bit at the offset
	b_first_a: assert property (o_out_valid && o_out_is_b && o_out_idx == 13'h000
		|-> o_out_ks_idx == st_r.offset)
		else $error("first b bit on wrong key bit");


	unprot_burst_c: cover property (st_r.fmt == bkm_pkg::bkm_fmt_unprot && $rose(o_done));
	multi_burst_c: cover property (st_r.fmt == bkm_pkg::bkm_fmt_multi && $rose(o_done));
	afield_c: cover property (o_out_valid && !o_out_is_b ##1 o_out_valid);
	cfg4b_c: cover property (st_r.cfg == bkm_pkg::bkm_cfg_4b && o_out_valid && o_out_is_b);
	ctrl_write_c: cover property (st_r.dp_write && st_r.dp_addr == `BKM_REG_CTRL);
endmodule : bkm_mapper

// file: tb/bkm_ks_model.sv
// key stream source model: offers key stream segment bits with their paired data bits
// assumes the mapper's clock; a one-cycle go pulse starts a segment of i_len bits
module bkm_ks_model (
	input wire i_mclk,
	input wire i_resetn,
	input wire i_go,
	input wire [12:0] i_len,
	input wire [1:0] i_gap,
	output logic o_ks_valid,
	output logic o_ks_bit,
	output logic o_data_bit,
	output logic o_running
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [12:0] idx;
	logic [1:0] wait_n;

	// key and data patterns as functions of the key bit index
	function automatic logic key_f(input logic [12:0] k);
		return k[0] ^ k[3] ^ k[6];
	endfunction : key_f
	function automatic logic dat_f(input logic [12:0] k);
		return k[1] ^ k[4] ^ k[9];
	endfunction : dat_f

	// one bit per offer, i_gap idle cycles between offers
	always @(posedge i_mclk) begin
		if (!i_resetn) begin
			o_running <= 1'b0;
			o_ks_valid <= 1'b0;
			o_ks_bit <= 1'b0;
			o_data_bit <= 1'b0;
			idx <= 13'h0;
			wait_n <= 2'h0;
		end else if (i_go) begin
			o_running <= 1'b1;
			o_ks_valid <= 1'b0;
			idx <= 13'h0;
			wait_n <= i_gap;
		end else if (o_running && wait_n == 2'h0) begin
			o_ks_valid <= 1'b1;
			o_ks_bit <= key_f(idx);
			o_data_bit <= dat_f(idx);
			idx <= idx + 13'h1;
			wait_n <= i_gap;
			if (idx == i_len - 13'h1) begin
				o_running <= 1'b0;
			end
		end else begin
			// stalled or idle: lines flip so a stale bit never looks current
			o_ks_valid <= 1'b0;
			o_ks_bit <= ~o_ks_bit;
			o_data_bit <= ~o_data_bit;
			if (wait_n != 2'h0) begin
				wait_n <= wait_n - 2'h1;
			end
		end
	end
endmodule : bkm_ks_model

// file: tb/tb_burst_keystream_xor_mapper.sv
// testbench for the burst key stream xor mapper: bursts over the slot tables, ahb-lite register access
// assumes bkm_params.svh on the include path and the key source model beside the mapper
`include "bkm_params.svh"

module tb_burst_keystream_xor_mapper;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_mclk = 1'b0;
	logic i_resetn = 1'b0;
	logic start = 1'b0, go = 1'b0, tail = 1'b0, hsel = 1'b0, hwrite = 1'b0, cur_multi = 1'b0, enc = 1'b1;
	bkm_pkg::bkm_cfg_e cfg = bkm_pkg::bkm_cfg_1a;
	bkm_pkg::bkm_slot_e slot = bkm_pkg::bkm_slot_full;
	bkm_pkg::bkm_fmt_e fmt = bkm_pkg::bkm_fmt_unprot;
	logic [12:0] seg_len = 13'h0, out_idx, out_ks_idx;
	logic [1:0] gap = 2'h0, htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic ks_valid, ks_bit, data_bit, ks_run, out_valid, out_bit, out_is_b, busy, done, hreadyout, hresp;
	int fails = 0, num_checks = 0, na = 0, nb = 0, cur_ofs = 40;

	bkm_ks_model ks (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_go(go), .i_len(seg_len), .i_gap(gap),
		.o_ks_valid(ks_valid), .o_ks_bit(ks_bit), .o_data_bit(data_bit), .o_running(ks_run));
	bkm_mapper dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_start(start), .i_cfg(cfg), .i_slot(slot),
		.i_fmt(fmt), .i_tail_ctl(tail), .i_ks_valid(ks_valid), .i_ks_bit(ks_bit), .i_data_bit(data_bit),
		.o_out_valid(out_valid), .o_out_bit(out_bit), .o_out_is_b(out_is_b), .o_out_idx(out_idx),
		.o_out_ks_idx(out_ks_idx), .o_busy(busy), .o_done(done), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout),
		.o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp));

	// clock of 40 ns period
	always #20 i_mclk = ~i_mclk;

	task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %0d seen %0d", name, exp, got);
		end
	endtask : chk_word

	task automatic chk_bit(input string name, input logic exp, input logic got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s: expected %b seen %b", name, exp, got);
		end
	endtask : chk_bit

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test

	// single ahb-lite transfer: address phase, then data phase, read data taken at its closing edge
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] r);
		@(posedge i_mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		@(posedge i_mclk);
		while (hreadyout !== 1'b1) @(posedge i_mclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge i_mclk);
		while (hreadyout !== 1'b1) @(posedge i_mclk);
		r = hrdata;
		chk_bit("hresp", 1'b0, hresp);
	endtask : ahb

	task automatic reg_rd(input logic [31:0] a, input logic [31:0] exp);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0, r);
		chk_word("register", exp, r);
		$display("register read at %0d finished", a);
	endtask : reg_rd

	task automatic run_burst(input bkm_pkg::bkm_cfg_e c, input bkm_pkg::bkm_slot_e s, input bkm_pkg::bkm_fmt_e f,
		input logic t, input int exp_b);
		int ofs;
		int n;
		ofs = c == bkm_pkg::bkm_cfg_4a ? 80 : c == bkm_pkg::bkm_cfg_4b ? 120 : 40;
		@(posedge i_mclk);
		cur_ofs = ofs;
		cur_multi = f == bkm_pkg::bkm_fmt_multi;
		na = 0;
		nb = 0;
		start <= 1'b1;
		go <= 1'b1;
		cfg <= c;
		slot <= s;
		fmt <= f;
		tail <= t;
		seg_len <= 13'(ofs + (cur_multi ? exp_b / 64 * 80 : exp_b) + 8);
		@(posedge i_mclk);
		start <= 1'b0;
		go <= 1'b0;
		cfg <= bkm_pkg::bkm_cfg_e'(~c);
		slot <= bkm_pkg::bkm_slot_half;
		fmt <= cur_multi ? bkm_pkg::bkm_fmt_unprot : bkm_pkg::bkm_fmt_multi;
		tail <= ~t;
		@(posedge i_mclk);
		chk_bit("busy", 1'b1, busy);
		chk_bit("done", 1'b0, done);
		n = 0;
		while (done !== 1'b1 && n < 20000) begin
			@(posedge i_mclk);
			n++;
		end
		while (ks_run === 1'b1) @(posedge i_mclk);
		repeat (3) @(posedge i_mclk);
		chk_word("b_count", exp_b, nb);
		chk_word("a_count", t ? ofs : 0, na);
		chk_bit("done", 1'b1, done);
		chk_bit("busy", 1'b0, busy);
		$display("burst cfg %0d slot %0d fmt %0d finished", c, s, f);
	endtask : run_burst

	function automatic int grp(input int c);
		case (c)
			0, 1: return 0;
			2, 4: return 1;
			3, 5: return 2;
			6: return 3;
			default: return 4;
		endcase
	endfunction : grp

	task automatic run_cfgs(input bkm_pkg::bkm_slot_e s, input bkm_pkg::bkm_fmt_e f, input int tbl[5]);
		for (int c = 0; c < 8; c++) begin
			run_burst(bkm_pkg::bkm_cfg_e'(c), s, f, c[0], tbl[grp(c)]);
		end
	endtask : run_cfgs

	// every mapped bit is checked for its key index and its value
	always @(posedge i_mclk) begin
		if (i_resetn && out_valid === 1'b1) begin
			if (out_is_b === 1'b1) begin
				chk_word("b_idx", nb, out_idx);
				nb++;
				chk_word("ks_idx", cur_multi ? (out_idx / 64) * 80 + out_idx % 64 + cur_ofs : out_idx + cur_ofs,
					out_ks_idx);
			end else begin
				chk_word("a_ks_idx", na, out_ks_idx);
				na++;
				chk_word("a_idx", out_ks_idx + 8, out_idx);
			end
			chk_bit("out_bit", ks.dat_f(out_ks_idx) ^ (enc & ks.key_f(out_ks_idx)), out_bit);
		end
	end

	// watchdog cuts a hang short
	initial begin
		repeat (96000) @(posedge i_mclk);
		fails++;
		stop_test();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge i_mclk);
		i_resetn <= 1'b1;
		reg_rd(32'(`BKM_REG_CTRL), 32'h1);
		ahb(1'b1, 32'h10, 32'hffffffff, rd);
		reg_rd(32'h10, 32'h0);
		gap <= 2'h1;
		run_cfgs(bkm_pkg::bkm_slot_full, bkm_pkg::bkm_fmt_single, '{304, 608, 928, 1248, 1888});
		gap <= 2'h0;
		run_cfgs(bkm_pkg::bkm_slot_long640, bkm_pkg::bkm_fmt_single, '{608, 1248, 1888, 2528, 3808});
		run_cfgs(bkm_pkg::bkm_slot_long672, bkm_pkg::bkm_fmt_single, '{640, 1312, 1984, 2556, 4000});
		run_cfgs(bkm_pkg::bkm_slot_long640, bkm_pkg::bkm_fmt_unprot, '{640, 1280, 1920, 2560, 3840});
		run_cfgs(bkm_pkg::bkm_slot_long672, bkm_pkg::bkm_fmt_unprot, '{672, 1344, 2016, 2688, 4032});
		run_burst(bkm_pkg::bkm_cfg_4a, bkm_pkg::bkm_slot_double, bkm_pkg::bkm_fmt_single, 1'b1, 1568);
		run_burst(bkm_pkg::bkm_cfg_4b, bkm_pkg::bkm_slot_double, bkm_pkg::bkm_fmt_single, 1'b0, 2368);
		run_burst(bkm_pkg::bkm_cfg_6, bkm_pkg::bkm_slot_double, bkm_pkg::bkm_fmt_single, 1'b1, 4768);
		run_burst(bkm_pkg::bkm_cfg_1a, bkm_pkg::bkm_slot_full, bkm_pkg::bkm_fmt_multi, 1'b0, 256);
		run_burst(bkm_pkg::bkm_cfg_4b, bkm_pkg::bkm_slot_long640, bkm_pkg::bkm_fmt_multi, 1'b1, 1536);
		run_burst(bkm_pkg::bkm_cfg_6, bkm_pkg::bkm_slot_half, bkm_pkg::bkm_fmt_unprot, 1'b1, 560);
		reg_rd(32'(`BKM_REG_STATUS), 32'h02300007);
		reg_rd(32'(`BKM_REG_BURSTS), 32'd46);
		ahb(1'b1, 32'(`BKM_REG_CTRL), 32'h0, rd);
		enc = 1'b0;
		run_burst(bkm_pkg::bkm_cfg_1b, bkm_pkg::bkm_slot_full, bkm_pkg::bkm_fmt_single, 1'b1, 304);
		reg_rd(32'(`BKM_REG_CTRL), 32'h0);
		// second reset in mid-run brings back the reset state
		i_resetn <= 1'b0;
		repeat (8) @(posedge i_mclk);
		i_resetn <= 1'b1;
		@(posedge i_mclk);
		chk_bit("done", 1'b0, done);
		chk_bit("busy", 1'b0, busy);
		enc = 1'b1;
		reg_rd(32'(`BKM_REG_CTRL), 32'h1);
		reg_rd(32'(`BKM_REG_BURSTS), 32'h0);
		stop_test();
	end
endmodule : tb_burst_keystream_xor_mapper
